/* ilcd_detector.sv */
// inband loop-up/loop-down code detector with register port
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "ilcd_params.svh"

module ilcd_code_track (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ilcd_pkg::ilcd_code_type i_code,
  input wire logic i_enable,
  input wire logic i_bit_valid,
  input wire logic i_bit,
  input wire logic i_err_ok,
  input wire logic i_win_end,
  output logic o_found
);
  import ilcd_pkg::*;

  logic [31:0] hist_q;
  logic [31:0] hist_d;
  logic [5:0] fill_q;
  logic [5:0] fill_d;
  logic [2:0] phase_q;
  logic [9:0] err_q;
  logic [6:0] good_q;
  logic found_q;
  ilcd_track_type state_q;
  logic [3:0] len;
  logic [3:0] hit;
  logic exp_bit;
  logic err_inc;
  logic win_good;
  logic lose;

  // code length from the two-bit select
  function automatic logic [3:0] code_len(input logic [1:0] sel);
    return `ILCD_MIN_CODE_LEN + {2'b00, sel};
  endfunction

  // search every phase for four clean repetitions; {hit, next phase}
  function automatic logic [3:0] find_phase(input logic [31:0] h,
      input logic [7:0] pat, input logic [3:0] l);
    logic [3:0] res;
    logic ok;
    logic [3:0] idx;
    integer q;
    integer i;
    res = 4'h0;
    for (q = 0; q < 8; q++) begin
      ok = (q < l);
      idx = (q == 0) ? l - 4'h1 : 4'(q - 1);
      for (i = 0; i < 32; i++) begin
        if ((i < 4 * l) && (h[i] != pat[3'(4'h7 - idx)])) begin
          ok = 1'b0;
        end
        idx = (idx == 4'h0) ? l - 4'h1 : idx - 4'h1;
      end
      if (ok && !res[3]) begin
        res = {1'b1, q[2:0]};
      end
    end
    return res;
  endfunction

  // comparison terms for the current bit
  assign len = code_len(i_code.len_sel);
  assign hist_d = {hist_q[30:0], i_bit};
  assign fill_d = (fill_q == 6'h20) ? fill_q : fill_q + 6'h01;
  assign hit = (fill_d >= {len, 2'b00}) ?
      find_phase(hist_d, i_code.pattern, len) : 4'h0;
  assign exp_bit = i_code.pattern[3'(3'h7 - phase_q)];
  assign err_inc = (state_q == ILCD_MONITOR) && i_bit_valid && i_err_ok &&
      (i_bit != exp_bit);
  assign win_good = (state_q == ILCD_MONITOR) && (err_q < `ILCD_ERR_LIMIT);
  assign lose = i_win_end && (state_q == ILCD_MONITOR) &&
      (err_q > `ILCD_ERR_LIMIT);

  // bit history of compared positions
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hist_q <= 32'h0;
      fill_q <= 6'h00;
    end else if (!i_enable) begin
      hist_q <= 32'h0;
      fill_q <= 6'h00;
    end else if (i_bit_valid) begin
      hist_q <= hist_d;
      fill_q <= fill_d;
    end
  end

  // lock state and expected phase
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ILCD_SEARCH;
      phase_q <= 3'h0;
    end else if (!i_enable || lose) begin
      state_q <= ILCD_SEARCH;
      phase_q <= 3'h0;
    end else if (i_bit_valid) begin
      if (state_q == ILCD_SEARCH) begin
        if (hit[3]) begin
          state_q <= ILCD_MONITOR;
          phase_q <= hit[2:0];
        end
      end else if ({1'b0, phase_q} == len - 4'h1) begin
        phase_q <= 3'h0;
      end else begin
        phase_q <= phase_q + 3'h1;
      end
    end
  end

  // error count per window, saturating
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      err_q <= 10'h000;
    end else if (!i_enable || i_win_end) begin
      err_q <= {9'h000, err_inc & i_enable};
    end else if (err_inc && (err_q != 10'h3FF)) begin
      err_q <= err_q + 10'h001;
    end
  end

  // consecutive good windows and found indication
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      good_q <= 7'h00;
      found_q <= 1'b0;
    end else if (!i_enable) begin
      good_q <= 7'h00;
      found_q <= 1'b0;
    end else if (i_win_end) begin
      if (win_good) begin
        if (good_q != 7'h7F) begin
          good_q <= good_q + 7'h01;
        end
        if (good_q >= `ILCD_GOOD_WINDOWS) begin
          found_q <= 1'b1;
        end
      end else begin
        good_q <= 7'h00;
        if (lose) begin
          found_q <= 1'b0;
        end
      end
    end
  end

  assign o_found = found_q;
endmodule

module ilcd_detector #(
  parameter int P_WINDOW_BITS = `ILCD_WINDOW_BITS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ilcd_pkg::ilcd_bus_type i_bus,
  output logic [7:0] o_rd_data,
  output logic o_irq_n,
  input wire logic i_line_clk,
  input wire ilcd_pkg::ilcd_line_type i_line
);
  import ilcd_pkg::*;

  logic [7:0] cfg_q;
  logic [7:0] up_code_q;
  logic [7:0] down_code_q;
  logic [1:0] mask_q;
  logic [1:0] flags_q;
  logic [1:0] clear_mask;
  logic [7:0] rd_data_q;
  logic irq_n_q;
  ilcd_cfg_type cfg_word;
  logic [1:0] found_meta_q;
  logic [1:0] found_sync_q;
  logic [1:0] found_prev_q;
  logic [1:0] change;
  logic lrst_meta_q;
  logic lrst_q;
  ilcd_cfg_type cfg_sent_q;
  logic cfg_req_q;
  logic cfg_busy;
  logic ack_meta_q;
  logic ack_sync_q;
  logic lreq_meta_q;
  logic lreq_sync_q;
  logic lack_q;
  ilcd_cfg_type lcfg_q;
  ilcd_line_type line_meta_q;
  ilcd_line_type line_q;
  logic [15:0] win_q;
  logic win_end;
  logic bit_valid;
  logic err_ok;
  logic [1:0] found_line;

  // ---- system clock domain ----
  // configuration bundle toward the line domain
  assign cfg_word.t1_mode = cfg_q[`ILCD_CFG_T1_MODE];
  assign cfg_word.unframed = cfg_q[`ILCD_CFG_UNFRAMED];
  assign cfg_word.fbit_cmp = cfg_q[`ILCD_CFG_FBIT_CMP];
  assign cfg_word.up.len_sel = cfg_q[`ILCD_CFG_UP_LEN_LSB +: 2];
  assign cfg_word.up.pattern = up_code_q;
  assign cfg_word.down.len_sel = cfg_q[`ILCD_CFG_DOWN_LEN_LSB +: 2];
  assign cfg_word.down.pattern = down_code_q;

  // handshake busy while the request toggle is unanswered
  assign cfg_busy = cfg_req_q ^ ack_sync_q;

  // word held steady while the line side takes it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_sent_q <= '0;
      cfg_req_q <= 1'b0;
    end else if (!cfg_busy && (cfg_sent_q != cfg_word)) begin
      cfg_sent_q <= cfg_word;
      cfg_req_q <= ~cfg_req_q;
    end
  end

  // writable registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= `ILCD_CFG_RST;
      up_code_q <= `ILCD_UP_CODE_RST;
      down_code_q <= `ILCD_DOWN_CODE_RST;
      mask_q <= `ILCD_MASK_RST;
    end else if (i_bus.wr) begin
      if (i_bus.addr == `ILCD_REG_CONFIG) begin
        cfg_q <= i_bus.wdata & `ILCD_CFG_MASK;
      end else if (i_bus.addr == `ILCD_REG_UP_CODE) begin
        up_code_q <= i_bus.wdata;
      end else if (i_bus.addr == `ILCD_REG_DOWN_CODE) begin
        down_code_q <= i_bus.wdata;
      end else if (i_bus.addr == `ILCD_REG_IRQ_MASK) begin
        mask_q <= i_bus.wdata[1:0];
      end
    end
  end

  // found and config acknowledge brought across, found edge detected
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      found_meta_q <= 2'h0;
      found_sync_q <= 2'h0;
      found_prev_q <= 2'h0;
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      found_meta_q <= found_line;
      found_sync_q <= found_meta_q;
      found_prev_q <= found_sync_q;
      ack_meta_q <= lack_q;
      ack_sync_q <= ack_meta_q;
    end
  end

  assign change = found_sync_q ^ found_prev_q;
  assign clear_mask = (i_bus.wr && (i_bus.addr == `ILCD_REG_IRQ_FLAGS)) ?
      i_bus.wdata[1:0] : 2'h0;

  // change flags: write one to clear, a new change wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= 2'h0;
    end else begin
      flags_q <= (flags_q & ~clear_mask) | change;
    end
  end

  // active-low interrupt from enabled flags
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~|(flags_q & mask_q);
    end
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_data_q <= 8'h00;
    end else if (!i_bus.rd) begin
      rd_data_q <= 8'h00;
    end else if (i_bus.addr == `ILCD_REG_CONFIG) begin
      rd_data_q <= cfg_q;
    end else if (i_bus.addr == `ILCD_REG_STATE) begin
      rd_data_q <= {6'h00, found_sync_q};
    end else if (i_bus.addr == `ILCD_REG_UP_CODE) begin
      rd_data_q <= up_code_q;
    end else if (i_bus.addr == `ILCD_REG_DOWN_CODE) begin
      rd_data_q <= down_code_q;
    end else if (i_bus.addr == `ILCD_REG_IRQ_MASK) begin
      rd_data_q <= {6'h00, mask_q};
    end else if (i_bus.addr == `ILCD_REG_IRQ_FLAGS) begin
      rd_data_q <= {6'h00, flags_q};
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_irq_n = irq_n_q;

  // ---- line clock domain ----
  // reset asserted at once, released on the line clock
  always_ff @(posedge i_line_clk or posedge i_rst) begin
    if (i_rst) begin
      lrst_meta_q <= 1'b1;
      lrst_q <= 1'b1;
    end else begin
      lrst_meta_q <= 1'b0;
      lrst_q <= lrst_meta_q;
    end
  end

  // request toggle brought into the line domain
  always_ff @(posedge i_line_clk or posedge lrst_q) begin
    if (lrst_q) begin
      lreq_meta_q <= 1'b0;
      lreq_sync_q <= 1'b0;
    end else begin
      lreq_meta_q <= cfg_req_q;
      lreq_sync_q <= lreq_meta_q;
    end
  end

  // held word taken once its request toggle arrives
  always_ff @(posedge i_line_clk or posedge lrst_q) begin
    if (lrst_q) begin
      lcfg_q <= '0;
      lack_q <= 1'b0;
    end else if (lreq_sync_q != lack_q) begin
      lcfg_q <= cfg_sent_q;
      lack_q <= lreq_sync_q;
    end
  end

  // received bits pass two stages before any compare
  always_ff @(posedge i_line_clk or posedge lrst_q) begin
    if (lrst_q) begin
      line_meta_q <= '0;
      line_q <= '0;
    end else begin
      line_meta_q <= i_line;
      line_q <= line_meta_q;
    end
  end

  // free-running window counter on received bits
  always_ff @(posedge i_line_clk or posedge lrst_q) begin
    if (lrst_q) begin
      win_q <= 16'h0000;
    end else if (win_end) begin
      win_q <= 16'h0000;
    end else begin
      win_q <= win_q + 16'h0001;
    end
  end

  assign win_end = (win_q == 16'(P_WINDOW_BITS - 1));

  // which bits are compared and which may count as errors
  assign bit_valid = lcfg_q.unframed || !line_q.fbit ||
      lcfg_q.fbit_cmp;
  assign err_ok = lcfg_q.unframed || !line_q.fbit;

  // loop-up and loop-down searches run side by side
  ilcd_code_track u_up (
    .i_clk(i_line_clk),
    .i_rst(lrst_q),
    .i_code(lcfg_q.up),
    .i_enable(lcfg_q.t1_mode),
    .i_bit_valid(bit_valid),
    .i_bit(line_q.data),
    .i_err_ok(err_ok),
    .i_win_end(win_end),
    .o_found(found_line[`ILCD_BIT_UP])
  );

  ilcd_code_track u_down (
    .i_clk(i_line_clk),
    .i_rst(lrst_q),
    .i_code(lcfg_q.down),
    .i_enable(lcfg_q.t1_mode),
    .i_bit_valid(bit_valid),
    .i_bit(line_q.data),
    .i_err_ok(err_ok),
    .i_win_end(win_end),
    .o_found(found_line[`ILCD_BIT_DOWN])
  );
endmodule

/* ilcd_params.svh */
// register map, field positions, reset values and timing counts
`ifndef ILCD_PARAMS_SVH
`define ILCD_PARAMS_SVH
// Summary of operation
// - detector works only when T1/J1 mode set
// - compare against two length-selectable programmed codes
// - framed: framing bit compared only if selected
// - unframed: every bit of frame is compared
// - errors counted after four clean code repetitions
// - found after over 126 windows under 600
// - window over 600 errors clears found
// - framed: framing bit never counts as error
// - any found change sets its change flag
// - flag drives low irq only when enabled

// register offsets
`define ILCD_REG_CONFIG 8'h76
`define ILCD_REG_STATE 8'h77
`define ILCD_REG_UP_CODE 8'h78
`define ILCD_REG_DOWN_CODE 8'h79
`define ILCD_REG_IRQ_MASK 8'h7A
`define ILCD_REG_IRQ_FLAGS 8'h7B

// configuration field positions
`define ILCD_CFG_UP_LEN_LSB 0
`define ILCD_CFG_DOWN_LEN_LSB 2
`define ILCD_CFG_FBIT_CMP 4
`define ILCD_CFG_UNFRAMED 5
`define ILCD_CFG_T1_MODE 6
`define ILCD_CFG_MASK 8'h7F

// status, mask and flag bit positions
`define ILCD_BIT_UP 0
`define ILCD_BIT_DOWN 1

// reset values
`define ILCD_CFG_RST 8'h40
`define ILCD_UP_CODE_RST 8'h00
`define ILCD_DOWN_CODE_RST 8'h00
`define ILCD_MASK_RST 2'h0

// timing and thresholds
`define ILCD_WINDOW_US 39800
`define ILCD_LINE_KHZ 1544
`define ILCD_WINDOW_BITS ((`ILCD_WINDOW_US * `ILCD_LINE_KHZ) / 1000)
`define ILCD_MIN_CODE_LEN 4'h5
`define ILCD_GOOD_WINDOWS 7'h7E
`define ILCD_ERR_LIMIT 10'h258
`endif

/* ilcd_pkg.sv */
// types shared by the loop code detector
package ilcd_pkg;
  // one programmed target code
  typedef struct packed {
    logic [1:0] len_sel;
    logic [7:0] pattern;
  } ilcd_code_type;

  // configuration handed to the line domain
  typedef struct packed {
    logic t1_mode;
    logic unframed;
    logic fbit_cmp;
    ilcd_code_type up;
    ilcd_code_type down;
  } ilcd_cfg_type;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ilcd_bus_type;

  // received line bit with framing position marker
  typedef struct packed {
    logic data;
    logic fbit;
  } ilcd_line_type;

  // per-code tracker states
  typedef enum logic {
    ILCD_SEARCH,
    ILCD_MONITOR
  } ilcd_track_type;
endpackage

/* ilcd_detector_monitor.sv */
// checker on the loop code detector register and irq ports
`timescale 1ns/1ps
module ilcd_detector_monitor #(
  parameter int P_WINDOW_BITS = 64
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ilcd_pkg::ilcd_bus_type i_bus,
  input wire logic [7:0] o_rd_data,
  input wire logic o_irq_n
);
  import ilcd_pkg::*;
  logic [1:0] mask_q;
  logic [7:0] up_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // shadow copies of the irq mask and up code
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_q <= 2'h0;
      up_q <= 8'h00;
    end else if (i_bus.wr && i_bus.addr == 8'h7A) begin
      mask_q <= i_bus.wdata[1:0];
    end else if (i_bus.wr && i_bus.addr == 8'h78) begin
      up_q <= i_bus.wdata;
    end
  end
  sequence s_rd(logic [7:0] a);
    i_bus.rd && i_bus.addr == a;
  endsequence
  AST_RD_IDLE: assert property (!i_bus.rd |=> o_rd_data == 8'h00)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (
    i_bus.rd && (i_bus.addr < 8'h76 || i_bus.addr > 8'h7B)
    |=> o_rd_data == 8'h00) else $error("unmapped read not zero");
  AST_STATE_RSVD: assert property (
    s_rd(8'h77) |=> o_rd_data[7:2] == 6'h00) else $error("state bits");
  AST_CFG_RSVD: assert property (
    s_rd(8'h76) |=> !o_rd_data[7]) else $error("config bit 7 set");
  AST_UP_CODE: assert property (
    s_rd(8'h78) |=> o_rd_data == $past(up_q)) else $error("up code");
  AST_MASK_RD: assert property (
    s_rd(8'h7A) |=> o_rd_data == {6'h00, $past(mask_q)})
    else $error("mask readback");
  AST_FLAG_RSVD: assert property (
    s_rd(8'h7B) |=> o_rd_data[7:2] == 6'h00) else $error("flag bits");
  AST_IRQ_MASKED: assert property ($past(mask_q) == 2'h0 |-> o_irq_n)
    else $error("irq with mask clear");
  AST_IRQ_FELL: assert property (
    $fell(o_irq_n) |-> $past(mask_q) != 2'h0) else $error("irq unmasked");
endmodule
bind ilcd_detector ilcd_detector_monitor #(.P_WINDOW_BITS(P_WINDOW_BITS))
  u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus),
  .o_rd_data(o_rd_data), .o_irq_n(o_irq_n));

/* ilcd_line_src.sv */
// far-end line model sending a repeating loop code
`timescale 1ns/1ps
module ilcd_line_src (
  input wire logic i_line_clk,
  input wire logic i_rst,
  input wire logic i_on,
  input wire logic [7:0] i_pat,
  input wire logic [3:0] i_len,
  input wire logic i_unframed,
  output ilcd_pkg::ilcd_line_type o_line
);
  import ilcd_pkg::*;
  logic [7:0] pos_q;
  logic [2:0] idx_q;
  // code bits skip the framing slot unless unframed
  always_ff @(posedge i_line_clk or posedge i_rst) begin
    if (i_rst) begin
      pos_q <= 8'h00;
      idx_q <= 3'h0;
      o_line <= '0;
    end else begin
      pos_q <= (pos_q == 8'hC0) ? 8'h00 : pos_q + 8'h01;
      o_line.fbit <= (pos_q == 8'h00);
      if ((pos_q == 8'h00 && !i_unframed) || !i_on) begin
        o_line.data <= 1'($urandom);
      end else begin
        o_line.data <= i_pat[3'h7 - idx_q];
        idx_q <= (idx_q == 3'(i_len - 4'h1)) ? 3'h0 : idx_q + 3'h1;
      end
    end
  end
endmodule

/* inband_loop_code_detector_tb_top.sv */
// self-checking bench for the loop code detector
`timescale 1ns/1ps
module inband_loop_code_detector_tb_top;
  import ilcd_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_line_clk = 1'b0;
  logic on = 1'b0;
  logic unf = 1'b0;
  logic [7:0] up_pat = 8'h80;
  logic [3:0] up_len = 4'h5;
  logic [1:0] usel = 2'h0;
  ilcd_bus_type bus = '0;
  ilcd_line_type line;
  logic [7:0] rd_data;
  logic irq_n;
  logic pend = 1'b0;
  logic [7:0] exp_q[$];
  int fails = 0;
  int total_checks = 0;

  always #2 i_clk = ~i_clk;
  // line clock, odd phase against the system clock
  initial begin
    #1.3;
    forever #7.5 i_line_clk = ~i_line_clk;
  end

  ilcd_detector #(.P_WINDOW_BITS(64)) uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_bus(bus), .o_rd_data(rd_data), .o_irq_n(irq_n),
    .i_line_clk(i_line_clk), .i_line(line));
  ilcd_line_src u_src (.i_line_clk(i_line_clk), .i_rst(i_rst), .i_on(on),
    .i_pat(up_pat), .i_len(up_len), .i_unframed(unf), .o_line(line));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one bus cycle per clock, strobes last one cycle
  task automatic op(input logic [7:0] a, input logic [7:0] d,
                    input logic w, input logic r);
    @(posedge i_clk);
    bus <= {a, d, w, r};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(a, 8'h00, 1'b0, 1'b1);
    exp_q.push_back(e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(a, d, 1'b1, 1'b0);
    op(8'h00, 8'h00, 1'b0, 1'b0);
  endtask
  // bounded wait for an interrupt level
  task automatic wait_irq(input logic lvl, input int n);
    int i;
    for (i = 0; i < n && irq_n !== lvl; i++) @(posedge i_clk);
    chk({7'h00, irq_n}, {7'h00, lvl});
    if (irq_n !== lvl) end_sim();
  endtask

  // oldest note against the answer of each read
  always @(posedge i_clk) begin
    if (pend) chk(rd_data, exp_q.pop_front());
    pend <= bus.rd;
  end

  initial begin
    void'($urandom(32'h6ABD7358));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset values, unmapped and read-only places
    rd(8'h76, 8'h40);
    for (int a = 8'h77; a <= 8'h7C; a++) rd(8'(a), 8'h00);
    wr(8'h7C, 8'hFF);
    wr(8'h77, 8'hFF);
    wr(8'h76, 8'hFF);
    rd(8'h76, 8'h7F);
    rd(8'h77, 8'h00);
    usel = 2'($urandom_range(2));
    up_pat = {2'b10, 6'($urandom)};
    up_len = 4'h5 + 4'(usel);
    wr(8'h76, {4'h4, usel + 2'h1, usel});
    op(8'h78, up_pat, 1'b1, 1'b0);
    rd(8'h78, up_pat);
    wr(8'h79, 8'($urandom));
    wr(8'h7A, 8'h03);
    on <= 1'b1;
    // not yet found after 125 windows, found soon after
    repeat (30000) @(posedge i_clk);
    chk({7'h00, irq_n}, 8'h01);
    wait_irq(1'b0, 1000);
    rd(8'h77, 8'h01);
    rd(8'h7B, 8'h01);
    wr(8'h7A, 8'h02);
    wait_irq(1'b1, 4);
    wr(8'h7A, 8'h01);
    wait_irq(1'b0, 4);
    wr(8'h7B, 8'h01);
    wait_irq(1'b1, 4);
    // leaving T1 mode drops found, a falling change
    wr(8'h76, {4'h0, usel + 2'h1, usel});
    wait_irq(1'b0, 100);
    rd(8'h77, 8'h00);
    rd(8'h7B, 8'h01);
    // loop-down code now sent, unframed, odd length
    usel = 2'({$urandom_range(1), 1'b0});
    up_pat = {2'b10, 6'($urandom)};
    up_len = 4'h5 + 4'(usel);
    unf = 1'b1;
    wr(8'h79, up_pat);
    // complement of an odd-length code never locks the up search
    wr(8'h78, ~up_pat);
    wr(8'h7B, 8'h03);
    wr(8'h7A, 8'h02);
    wr(8'h76, {4'h6, usel, usel});
    repeat (30000) @(posedge i_clk);
    chk({7'h00, irq_n}, 8'h01);
    wait_irq(1'b0, 1000);
    rd(8'h77, 8'h02);
    rd(8'h7B, 8'h02);
    op(8'h00, 8'h00, 1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    end_sim();
  end
endmodule
